// *** core/fap_config_bank.sv ***
// FIFO fill and auxiliary poll configuration bank with its control logic
//
// Summary of operation
// - Aux rate codes 1..11 poll from 25/32 Hz to 800 Hz, others idle.
// - The aux delay field sets trigger-to-readout offset in 2.5 ms steps.
// - A zero delay issues the next trigger right after a readout.
// - Accel samples into the FIFO are decimated by two to the field power.
// - Bit 7 of the decimation register picks filtered or unfiltered data.
// - The 13-bit byte watermark spans the low register and high bits 4..0.
// - With halt-when-full set, no frame is written while the FIFO is full.
// - With timestamp-append set, a time frame follows the last data frame.
// - With header enable set, each stored frame carries a header.
// - The aux store bit enables three-axis aux data into the FIFO.
// - The accel store bit enables three-axis accel data into the FIFO.
// - Bits 3 and 2 enable tagging frames with interrupt lines one and two.
// - The aux target register keeps a 7-bit I2C address in bits 7..1.
// - Each register resets to its listed value.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module fap_config_bank #(
   parameter int POLL_BASE = fap_pkg::POLL_BASE_CYC,
   parameter int DELAY_UNIT = fap_pkg::DELAY_UNIT_CYC
) (
   input wire logic ref_clk,                   // System clock
   input wire logic sys_rst,                   // Async reset, high
   input wire logic [fap_pkg::ADDR_W-1:0] regAddr,  // Register address
   input wire logic [fap_pkg::DATA_W-1:0] regWdata, // Write data
   input wire logic regWr,                     // Write strobe
   input wire logic regRd,                     // Read strobe
   output logic [fap_pkg::DATA_W-1:0] regRdata,     // Read data, next cycle
   input wire logic accValid,                  // Accel sample strobe
   input wire fap_pkg::fap_axes_type accRaw,   // Unfiltered accel
   input wire fap_pkg::fap_axes_type accFilt,  // Filtered accel
   input wire logic auxValid,                  // Aux sample strobe
   input wire fap_pkg::fap_axes_type auxAxes,  // Aux sample
   input wire logic irqLineOne,                // Interrupt line one level
   input wire logic irqLineTwo,                // Interrupt line two level
   input wire logic fifoFull,                  // FIFO full
   input wire logic [fap_pkg::LEVEL_W-1:0] fifoLevel, // FIFO fill, bytes
   input wire logic lastFrameRead,             // Reader passed last frame
   output logic frameWr,                       // Frame write pulse
   output fap_pkg::fap_frame_type frame,       // Frame to store
   output logic timeFrameReq,                  // Append time frame pulse
   output logic watermarkHit,                  // Level at/above watermark
   output logic auxTrigger,                    // Aux trigger pulse
   output logic auxReadout,                    // Aux readout pulse
   output logic [6:0] auxTargetAddr            // Aux I2C address
);
   import fap_pkg::*;

   function automatic logic [7:0] maskedWrite(input logic [7:0] oldVal,
                                              input logic [7:0] newVal,
                                              input logic [7:0] msk);
      maskedWrite = (oldVal & ~msk) | (newVal & msk);
   endfunction

   // Register file
   logic [7:0] auxPoll_ff, nxt_auxPoll;
   logic [7:0] decim_ff, nxt_decim;
   logic [7:0] wmLo_ff, nxt_wmLo;
   logic [7:0] wmHi_ff, nxt_wmHi;
   logic [7:0] frameCtl_ff, nxt_frameCtl;
   logic [7:0] content_ff, nxt_content;
   logic [7:0] auxAddr_ff, nxt_auxAddr;
   logic [7:0] rdata_ff, nxt_rdata;

   always_comb begin
      nxt_auxPoll = auxPoll_ff;
      nxt_decim = decim_ff;
      nxt_wmLo = wmLo_ff;
      nxt_wmHi = wmHi_ff;
      nxt_frameCtl = frameCtl_ff;
      nxt_content = content_ff;
      nxt_auxAddr = auxAddr_ff;
      nxt_rdata = RD_UNMAPPED;
      if (regWr) begin
         case (regAddr)
            OFS_AUX_POLL: begin
               nxt_auxPoll = maskedWrite(auxPoll_ff, regWdata, MSK_AUX_POLL);
            end
            OFS_DECIM: begin
               nxt_decim = maskedWrite(decim_ff, regWdata, MSK_DECIM);
            end
            OFS_WM_LO: begin
               nxt_wmLo = maskedWrite(wmLo_ff, regWdata, MSK_WM_LO);
            end
            OFS_WM_HI: begin
               nxt_wmHi = maskedWrite(wmHi_ff, regWdata, MSK_WM_HI);
            end
            OFS_FRAME_CTL: begin
               nxt_frameCtl = maskedWrite(frameCtl_ff, regWdata,
                                          MSK_FRAME_CTL);
            end
            OFS_CONTENT: begin
               nxt_content = maskedWrite(content_ff, regWdata,
                                         MSK_CONTENT);
            end
            OFS_AUX_ADDR: begin
               nxt_auxAddr = maskedWrite(auxAddr_ff, regWdata,
                                         MSK_AUX_ADDR);
            end
            default: begin
            end
         endcase
      end
      if (regRd) begin
         case (regAddr)
            OFS_AUX_POLL: nxt_rdata = auxPoll_ff;
            OFS_DECIM: nxt_rdata = decim_ff & MSK_DECIM;
            OFS_WM_LO: nxt_rdata = wmLo_ff;
            OFS_WM_HI: nxt_rdata = wmHi_ff & MSK_WM_HI;
            OFS_FRAME_CTL: nxt_rdata = frameCtl_ff & MSK_FRAME_CTL;
            OFS_CONTENT: nxt_rdata = content_ff & MSK_CONTENT;
            OFS_AUX_ADDR: nxt_rdata = auxAddr_ff & MSK_AUX_ADDR;
            default: nxt_rdata = RD_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         auxPoll_ff <= RST_AUX_POLL;
         decim_ff <= RST_DECIM;
         wmLo_ff <= RST_WM_LO;
         wmHi_ff <= RST_WM_HI;
         frameCtl_ff <= RST_FRAME_CTL;
         content_ff <= RST_CONTENT;
         auxAddr_ff <= RST_AUX_ADDR;
         rdata_ff <= RD_UNMAPPED;
      end else begin
         auxPoll_ff <= nxt_auxPoll;
         decim_ff <= nxt_decim;
         wmLo_ff <= nxt_wmLo;
         wmHi_ff <= nxt_wmHi;
         frameCtl_ff <= nxt_frameCtl;
         content_ff <= nxt_content;
         auxAddr_ff <= nxt_auxAddr;
         rdata_ff <= nxt_rdata;
      end
   end

   assign regRdata = rdata_ff;
   assign auxTargetAddr = auxAddr_ff[ADDR_LSB +: 7];

   // Field views
   logic stopOnFull, timeEn, headerEn, auxEn, accEn, tagOneEn, tagTwoEn;
   logic [WM_W-1:0] watermark;
   assign stopOnFull = frameCtl_ff[STOP_BIT];
   assign timeEn = frameCtl_ff[TIME_BIT];
   assign headerEn = content_ff[HDR_BIT];
   assign auxEn = content_ff[AUXEN_BIT];
   assign accEn = content_ff[ACCEN_BIT];
   assign tagOneEn = content_ff[TAG1_BIT];
   assign tagTwoEn = content_ff[TAG2_BIT];
   assign watermark = {wmHi_ff[WM_W-9:0], wmLo_ff};

   // Aux poll scheduling
   fap_poll_timer #(
      .BASE_CYC(POLL_BASE),
      .UNIT_CYC(DELAY_UNIT)
   ) u_poll (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .rateCode(auxPoll_ff[AUX_RATE_LSB +: 4]),
      .delayCode(auxPoll_ff[AUX_DELAY_LSB +: 4]),
      .trigPulse(auxTrigger),
      .readPulse(auxReadout)
   );

   // Accel decimation and source choice
   logic decValid;
   fap_axes_type decAxes;
   fap_decimator u_decim (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .factorCode(decim_ff[DECIM_LSB +: 3]),
      .useFiltered(decim_ff[FILT_BIT]),
      .sampleValid(accValid),
      .rawAxes(accRaw),
      .filtAxes(accFilt),
      .outValid(decValid),
      .outAxes(decAxes)
   );

   // Frame assembly
   logic pendAcc_ff, nxt_pendAcc;
   logic pendAux_ff, nxt_pendAux;
   fap_axes_type accHold_ff, nxt_accHold;
   fap_axes_type auxHold_ff, nxt_auxHold;
   logic wr_ff, nxt_wr;
   fap_frame_type frame_ff, nxt_frame;
   logic time_ff, nxt_time;
   logic wm_ff, nxt_wm;
   logic accIn, auxIn, frameReady;

   always_comb begin
      accIn = accEn && decValid;
      auxIn = auxEn && auxValid;
      nxt_pendAcc = accEn && (pendAcc_ff || accIn);
      nxt_pendAux = auxEn && (pendAux_ff || auxIn);
      nxt_accHold = accIn ? decAxes : accHold_ff;
      nxt_auxHold = auxIn ? auxAxes : auxHold_ff;
      // Headerless frames wait for every enabled source
      if (headerEn) begin
         frameReady = nxt_pendAcc || nxt_pendAux;
      end else begin
         frameReady = (accEn || auxEn) && (nxt_pendAcc || !accEn) &&
                      (nxt_pendAux || !auxEn);
      end
      nxt_wr = 1'b0;
      nxt_frame = frame_ff;
      if (frameReady) begin
         nxt_pendAcc = 1'b0;
         nxt_pendAux = 1'b0;
         if (!(stopOnFull && fifoFull)) begin
            nxt_wr = 1'b1;
            nxt_frame.hasHeader = headerEn;
            nxt_frame.hasAcc = accEn && (pendAcc_ff || accIn);
            nxt_frame.hasAux = auxEn && (pendAux_ff || auxIn);
            nxt_frame.tagOne = tagOneEn && irqLineOne;
            nxt_frame.tagTwo = tagTwoEn && irqLineTwo;
            nxt_frame.acc = nxt_accHold;
            nxt_frame.aux = nxt_auxHold;
         end
      end
      nxt_time = timeEn && lastFrameRead;
      nxt_wm = fifoLevel >= {1'b0, watermark};
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pendAcc_ff <= 1'b0;
         pendAux_ff <= 1'b0;
         accHold_ff <= '0;
         auxHold_ff <= '0;
         wr_ff <= 1'b0;
         frame_ff <= '0;
         time_ff <= 1'b0;
         wm_ff <= 1'b0;
      end else begin
         pendAcc_ff <= nxt_pendAcc;
         pendAux_ff <= nxt_pendAux;
         accHold_ff <= nxt_accHold;
         auxHold_ff <= nxt_auxHold;
         wr_ff <= nxt_wr;
         frame_ff <= nxt_frame;
         time_ff <= nxt_time;
         wm_ff <= nxt_wm;
      end
   end

   assign frameWr = wr_ff;
   assign frame = frame_ff;
   assign timeFrameReq = time_ff;
   assign watermarkHit = wm_ff;
endmodule

// *** inc/fap_pkg.sv ***
// Constants, register map and carrier types of the FIFO and aux poll bank
package fap_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int WM_W = 13;
   localparam int LEVEL_W = 14;
   localparam int DECIM_CNT_W = 7;
   localparam int POLL_CNT_W = 32;
   // Register offsets
   localparam logic [7:0] OFS_AUX_POLL = 8'h44;
   localparam logic [7:0] OFS_DECIM = 8'h45;
   localparam logic [7:0] OFS_WM_LO = 8'h46;
   localparam logic [7:0] OFS_WM_HI = 8'h47;
   localparam logic [7:0] OFS_FRAME_CTL = 8'h48;
   localparam logic [7:0] OFS_CONTENT = 8'h49;
   localparam logic [7:0] OFS_AUX_ADDR = 8'h4B;
   // Reset values
   localparam logic [7:0] RST_AUX_POLL = 8'h46;
   localparam logic [7:0] RST_DECIM = 8'h80;
   localparam logic [7:0] RST_WM_LO = 8'h00;
   localparam logic [7:0] RST_WM_HI = 8'h02;
   localparam logic [7:0] RST_FRAME_CTL = 8'h02;
   localparam logic [7:0] RST_CONTENT = 8'h10;
   localparam logic [7:0] RST_AUX_ADDR = 8'h20;
   // Writable bits; all others read zero
   localparam logic [7:0] MSK_AUX_POLL = 8'hFF;
   localparam logic [7:0] MSK_DECIM = 8'hF0;
   localparam logic [7:0] MSK_WM_LO = 8'hFF;
   localparam logic [7:0] MSK_WM_HI = 8'h1F;
   localparam logic [7:0] MSK_FRAME_CTL = 8'h03;
   localparam logic [7:0] MSK_CONTENT = 8'h7C;
   localparam logic [7:0] MSK_AUX_ADDR = 8'hFE;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;
   // Field positions
   localparam int AUX_RATE_LSB = 0;
   localparam int AUX_DELAY_LSB = 4;
   localparam int DECIM_LSB = 4;
   localparam int FILT_BIT = 7;
   localparam int STOP_BIT = 0;
   localparam int TIME_BIT = 1;
   localparam int TAG2_BIT = 2;
   localparam int TAG1_BIT = 3;
   localparam int HDR_BIT = 4;
   localparam int AUXEN_BIT = 5;
   localparam int ACCEN_BIT = 6;
   localparam int ADDR_LSB = 1;
   // Valid poll rate codes
   localparam logic [3:0] RATE_MIN = 4'h1;
   localparam logic [3:0] RATE_MAX = 4'hB;
   // Timing
   localparam real CLK_MHZ = 250.0;
   localparam real AUX_FASTEST_RATE_HZ = 800.0;
   localparam real AUX_DELAY_UNIT_MS = 2.5;
   localparam int POLL_BASE_CYC = $rtoi(CLK_MHZ * 1.0E6 / AUX_FASTEST_RATE_HZ);
   localparam int DELAY_UNIT_CYC = $rtoi(AUX_DELAY_UNIT_MS * CLK_MHZ * 1.0E3);

   typedef struct packed {
      logic [15:0] x;
      logic [15:0] y;
      logic [15:0] z;
   } fap_axes_type;

   typedef struct packed {
      logic hasHeader;
      logic hasAcc;
      logic hasAux;
      logic tagOne;
      logic tagTwo;
      fap_axes_type acc;
      fap_axes_type aux;
   } fap_frame_type;
endpackage

// *** core/fap_poll_timer.sv ***
// Auxiliary sensor poll scheduler: readout period and trigger offset
`timescale 1ns/1ps
module fap_poll_timer #(
   parameter int BASE_CYC = fap_pkg::POLL_BASE_CYC,
   parameter int UNIT_CYC = fap_pkg::DELAY_UNIT_CYC
) (
   input wire logic ref_clk,         // System clock
   input wire logic sys_rst,         // Async reset, high
   input wire logic [3:0] rateCode,  // Poll rate code
   input wire logic [3:0] delayCode, // Trigger offset code
   output logic trigPulse,           // Trigger to aux sensor
   output logic readPulse            // Readout of aux sensor
);
   import fap_pkg::*;
   localparam logic [POLL_CNT_W-1:0] BASE = POLL_CNT_W'(BASE_CYC);
   localparam logic [POLL_CNT_W-1:0] UNIT = POLL_CNT_W'(UNIT_CYC);
   localparam logic [POLL_CNT_W-1:0] ONE = POLL_CNT_W'(1);

   logic [POLL_CNT_W-1:0] cnt_ff, nxt_cnt;
   logic [3:0] rate_ff, nxt_rate;
   logic trig_ff, nxt_trig;
   logic read_ff, nxt_read;
   logic rateOk;
   logic [POLL_CNT_W-1:0] period, offsetCyc, trigAt;

   always_comb begin
      rateOk = (rateCode >= RATE_MIN) && (rateCode <= RATE_MAX);
      period = BASE << (RATE_MAX - rateCode);
      offsetCyc = UNIT * POLL_CNT_W'(delayCode);
      // Zero offset, or one of period minus one or more, fires right after readout
      if (delayCode == 4'h0 || offsetCyc >= period - ONE) begin
         trigAt = period - ONE;
      end else begin
         trigAt = offsetCyc;
      end
      nxt_rate = rateCode;
      nxt_cnt = cnt_ff;
      nxt_read = 1'b0;
      nxt_trig = 1'b0;
      if (!rateOk || rateCode != rate_ff) begin
         nxt_cnt = period - ONE;
      end else if (cnt_ff == '0) begin
         nxt_read = 1'b1;
         nxt_cnt = period - ONE;
      end else begin
         nxt_cnt = cnt_ff - ONE;
      end
      if (rateOk && rateCode == rate_ff && cnt_ff == trigAt) begin
         nxt_trig = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_ff <= '0;
         rate_ff <= 4'h0;
         trig_ff <= 1'b0;
         read_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         rate_ff <= nxt_rate;
         trig_ff <= nxt_trig;
         read_ff <= nxt_read;
      end
   end

   assign trigPulse = trig_ff;
   assign readPulse = read_ff;
endmodule

// *** core/fap_decimator.sv ***
// Accelerometer source select and power-of-two decimation for the FIFO
`timescale 1ns/1ps
module fap_decimator (
   input wire logic ref_clk,                // System clock
   input wire logic sys_rst,                // Async reset, high
   input wire logic [2:0] factorCode,       // Decimation exponent
   input wire logic useFiltered,            // Pick filtered source
   input wire logic sampleValid,            // New accel sample
   input wire fap_pkg::fap_axes_type rawAxes,  // Unfiltered sample
   input wire fap_pkg::fap_axes_type filtAxes, // Filtered sample
   output logic outValid,                   // Kept sample pulse
   output fap_pkg::fap_axes_type outAxes    // Kept sample
);
   import fap_pkg::*;
   localparam logic [DECIM_CNT_W-1:0] ONE = DECIM_CNT_W'(1);

   logic [DECIM_CNT_W-1:0] cnt_ff, nxt_cnt;
   logic valid_ff, nxt_valid;
   fap_axes_type axes_ff, nxt_axes;
   logic [DECIM_CNT_W-1:0] mask;

   always_comb begin
      mask = (ONE << factorCode) - ONE;
      nxt_cnt = cnt_ff;
      nxt_valid = 1'b0;
      nxt_axes = axes_ff;
      if (sampleValid) begin
         nxt_cnt = (cnt_ff + ONE) & mask;
         if ((cnt_ff & mask) == '0) begin
            nxt_valid = 1'b1;
            nxt_axes = useFiltered ? filtAxes : rawAxes;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_ff <= '0;
         valid_ff <= 1'b0;
         axes_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
         valid_ff <= nxt_valid;
         axes_ff <= nxt_axes;
      end
   end

   assign outValid = valid_ff;
   assign outAxes = axes_ff;
endmodule

// *** sim/fap_config_bank_chk.sv ***
// Port-level assertions for the FIFO and aux poll configuration bank
`timescale 1ns/1ps
module fap_config_bank_chk
   import fap_pkg::*;
(
   input wire logic ref_clk, // Clock
   input wire logic sys_rst, // Async reset
   input wire logic [7:0] regAddr, // Address
   input wire logic [7:0] regWdata, // Write data
   input wire logic regWr, // Write strobe
   input wire logic regRd, // Read strobe
   input wire logic [7:0] regRdata, // Read data
   input wire logic auxValid, // Aux strobe
   input wire fap_pkg::fap_axes_type auxAxes, // Aux sample
   input wire logic fifoFull, // Full
   input wire logic [13:0] fifoLevel, // Fill level
   input wire logic lastFrameRead, // Last frame read
   input wire logic frameWr, // Frame write
   input wire fap_pkg::fap_frame_type frame, // Frame
   input wire logic timeFrameReq, // Time frame
   input wire logic watermarkHit, // Watermark
   input wire logic auxTrigger, // Aux trigger
   input wire logic auxReadout, // Aux readout
   input wire logic [6:0] auxTargetAddr // Aux address
);
   logic [7:0] auxSh_ff, ctlSh_ff, contSh_ff, wmLo_ff, wmHi_ff;
   logic [7:0] nxt_auxSh, nxt_ctlSh, nxt_contSh, nxt_wmLo, nxt_wmHi;
   logic wrA;
   assign wrA = regWr && regAddr == OFS_AUX_ADDR;
   // Shadow copies of the registers the properties depend on
   always_comb begin
      nxt_auxSh = auxSh_ff;
      nxt_ctlSh = ctlSh_ff;
      nxt_contSh = contSh_ff;
      nxt_wmLo = wmLo_ff;
      nxt_wmHi = wmHi_ff;
      if (regWr && regAddr == OFS_AUX_POLL) nxt_auxSh = regWdata;
      if (regWr && regAddr == OFS_FRAME_CTL) nxt_ctlSh = regWdata & 8'h03;
      if (regWr && regAddr == OFS_CONTENT) nxt_contSh = regWdata & 8'h7C;
      if (regWr && regAddr == OFS_WM_LO) nxt_wmLo = regWdata;
      if (regWr && regAddr == OFS_WM_HI) nxt_wmHi = regWdata & 8'h1F;
   end
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         auxSh_ff <= RST_AUX_POLL;
         ctlSh_ff <= RST_FRAME_CTL;
         contSh_ff <= RST_CONTENT;
         wmLo_ff <= RST_WM_LO;
         wmHi_ff <= RST_WM_HI;
      end else begin
         auxSh_ff <= nxt_auxSh;
         ctlSh_ff <= nxt_ctlSh;
         contSh_ff <= nxt_contSh;
         wmLo_ff <= nxt_wmLo;
         wmHi_ff <= nxt_wmHi;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   rdata_idle_a: assert property (!$past(regRd) |-> regRdata == 8'h00)
      else $error("read data not zero when idle");
   unmapped_rd_a: assert property (regRd && !(regAddr inside {8'h44,
      8'h45, 8'h46, 8'h47, 8'h48, 8'h49, 8'h4B}) |=> regRdata == 8'h00)
      else $error("unmapped read not zero");
   target_addr_a: assert property (wrA ##1 !wrA |=>
      auxTargetAddr == $past(regWdata[7:1], 2))
      else $error("aux target address wrong");
   aux_frame_a: assert property (auxValid && !regWr && contSh_ff[5]
      && contSh_ff[4] && !ctlSh_ff[0] |=> frameWr && frame.hasAux
      && frame.aux == $past(auxAxes)) else $error("aux frame missing");
   full_halt_a: assert property ((fifoFull && ctlSh_ff[0]) [*3]
      |-> !frameWr) else $error("frame written when full");
   time_req_a: assert property (lastFrameRead && !regWr |=>
      timeFrameReq == $past(ctlSh_ff[1])) else $error("time frame wrong");
   wm_hit_a: assert property (1'b1 |=> watermarkHit ==
      ($past(fifoLevel) >= {$past(wmHi_ff), $past(wmLo_ff)}))
      else $error("watermark flag wrong");
   rate_off_a: assert property ((auxSh_ff[3:0] == 4'h0
      || auxSh_ff[3:0] > 4'hB) [*3] |-> !auxReadout && !auxTrigger)
      else $error("pulse at reserved rate");
   readout_gap_a: assert property (auxReadout |=> !auxReadout [*8])
      else $error("readouts too close");
   zero_delay_a: assert property (auxReadout && !regWr
      && auxSh_ff[7:4] == 4'h0 && $stable(auxSh_ff) |=> auxTrigger)
      else $error("no trigger after readout");
   hdr_flag_a: assert property (frameWr
      && contSh_ff == $past(contSh_ff, 3) |-> frame.hasHeader == contSh_ff[4])
      else $error("header flag wrong");
endmodule

// *** sim/fap_host_model.sv ***
// Host software model driving the register port
`timescale 1ns/1ps
module fap_host_model (
   input wire logic ref_clk, // Clock
   output logic [7:0] regAddr, // Address
   output logic [7:0] regWdata, // Write data
   output logic regWr, // Write strobe
   output logic regRd, // Read strobe
   input wire logic [7:0] regRdata // Read data
);
   initial begin
      regAddr = 8'h00;
      regWdata = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= v;
      @(posedge ref_clk);
      regWr <= 1'b0;
   endtask
   // Data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge ref_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRd <= 1'b0;
      @(posedge ref_clk);
      v = regRdata;
   endtask
endmodule

// *** sim/fap_config_bank_tb.sv ***
// Self-checking bench for the FIFO and aux poll configuration bank
`timescale 1ns/1ps
module fap_config_bank_tb;
   import fap_pkg::*;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] regAddr, regWdata, regRdata, d;
   logic regWr, regRd, frameWr, timeFrameReq, watermarkHit;
   logic auxTrigger, auxReadout;
   logic accValid = 1'b0, auxValid = 1'b0, lastFrameRead = 1'b0;
   logic irqLineOne = 1'b0, irqLineTwo = 1'b0, fifoFull = 1'b0;
   fap_axes_type accRaw = '0, accFilt = '0, auxAxes = '0;
   logic [13:0] fifoLevel = 14'h0000;
   fap_frame_type frame, f;
   logic [6:0] auxTargetAddr;
   logic [31:0] seed = 32'h7F537BFB;
   logic [7:0] adr [7] = '{OFS_AUX_POLL, OFS_DECIM, OFS_WM_LO, OFS_WM_HI,
      OFS_FRAME_CTL, OFS_CONTENT, OFS_AUX_ADDR};
   logic [7:0] rv [7] = '{RST_AUX_POLL, RST_DECIM, RST_WM_LO, RST_WM_HI,
      RST_FRAME_CTL, RST_CONTENT, RST_AUX_ADDR};
   logic [7:0] mk [7] = '{MSK_AUX_POLL, MSK_DECIM, MSK_WM_LO, MSK_WM_HI,
      MSK_FRAME_CTL, MSK_CONTENT, MSK_AUX_ADDR};
   logic [7:0] mdl [7];
   // Single source whenever headers are off
   logic [7:0] cc [6] = '{8'h10, 8'h10, 8'h20, 8'h70, 8'h70, 8'h70};
   logic [5:0] stp = 6'b101000, ful = 6'b111000;
   logic [5:0] isA = 6'b100001, exF = 6'b010100;
   int err_count = 0, samples_checked = 0, n, g;
   always #2 ref_clk = ~ref_clk;
   fap_config_bank #(.POLL_BASE(40), .DELAY_UNIT(8)) fap_config_bank_inst (
      .ref_clk, .sys_rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
      .accValid, .accRaw, .accFilt, .auxValid, .auxAxes, .irqLineOne,
      .irqLineTwo, .fifoFull, .fifoLevel, .lastFrameRead, .frameWr, .frame,
      .timeFrameReq, .watermarkHit, .auxTrigger, .auxReadout, .auxTargetAddr);
   fap_host_model fap_host_model_inst (.ref_clk, .regAddr, .regWdata,
      .regWr, .regRd, .regRdata);
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic fap_axes_type axes();
      logic [63:0] r;
      r = {rnd(), rnd()};
      return r[47:0];
   endfunction
   task automatic chk(string nm, logic [63:0] e, logic [63:0] s);
      samples_checked++;
      if (e !== s) begin
         err_count++;
         $display("FAIL %s expected %0h seen %0h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      fap_host_model_inst.wr(a, v);
   endtask
   task automatic send(input bit acc, output int cnt);
      @(posedge ref_clk);
      accValid <= acc;
      auxValid <= !acc;
      accRaw <= axes();
      accFilt <= axes();
      auxAxes <= axes();
      @(posedge ref_clk);
      accValid <= 1'b0;
      auxValid <= 1'b0;
      cnt = 0;
      repeat (4) begin
         #1;
         if (frameWr === 1'b1) begin
            cnt++;
            f = frame;
         end
         @(posedge ref_clk);
      end
   endtask
   // Edges from event a to event b; 1 is trigger, 0 is readout
   task automatic gap(input bit a, input bit b, output int cnt);
      for (int t = 0; t < 2000; t++) begin
         @(posedge ref_clk);
         #1;
         if ((a ? auxTrigger : auxReadout) === 1'b1) break;
      end
      for (cnt = 1; cnt < 2000; cnt++) begin
         @(posedge ref_clk);
         #1;
         if ((b ? auxTrigger : auxReadout) === 1'b1) break;
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      #200000;
      err_count++;
      report_and_stop();
   end
   initial begin
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 7; i++) begin
         fap_host_model_inst.rd(adr[i], d);
         chk("reset value", rv[i], d);
      end
      chk("target reset", 7'h10, auxTargetAddr);
      for (int k = 0; k < 3; k++) begin
         for (int i = 0; i < 7; i++) begin
            mdl[i] = (k == 0) ? 8'hFF : 8'(rnd());
            wr(adr[i], mdl[i]);
            mdl[i] &= mk[i];
         end
         wr(8'h4A, 8'hFF);
         for (int i = 0; i < 8; i++) begin
            fap_host_model_inst.rd((i < 7) ? adr[i] : 8'h4A, d);
            chk("read back", (i < 7) ? mdl[i] : RD_UNMAPPED, d);
         end
         chk("target", mdl[6][7:1], auxTargetAddr);
      end
      $display("test registers done");
      wr(OFS_WM_LO, 8'h34);
      wr(OFS_WM_HI, 8'hE5);
      for (int o = -1; o < 2; o++) begin
         fifoLevel <= 14'(32'h534 + o);
         repeat (3) @(posedge ref_clk);
         #1;
         chk("watermark", o >= 0, watermarkHit);
      end
      $display("test watermark done");
      wr(OFS_FRAME_CTL, 8'h00);
      wr(OFS_CONTENT, 8'h7C);
      for (int i = 0; i < 4; i++) begin
         irqLineOne <= i[0];
         irqLineTwo <= !i[0];
         wr(OFS_DECIM, {i[1], 7'h00});
         send(i[0], n);
         chk("frames", 1, n);
         chk("data", i[0] ? (i[1] ? accFilt : accRaw) : auxAxes,
            i[0] ? f.acc : f.aux);
         chk("tags", {2{i[0], !i[0]}},
            {f.hasAcc, f.hasAux, f.tagOne, f.tagTwo});
         chk("header", 1, f.hasHeader);
      end
      for (int i = 0; i < 6; i++) begin
         wr(OFS_CONTENT, cc[i]);
         wr(OFS_FRAME_CTL, {7'h00, stp[i]});
         fifoFull <= ful[i];
         send(isA[i], n);
         chk("gated frames", exF[i], n);
         if (i == 2) chk("no header", 0, f.hasHeader);
      end
      fifoFull <= 1'b0;
      wr(OFS_CONTENT, 8'h50);
      for (int k = 0; k < 4; k++) begin
         wr(OFS_DECIM, 8'(k << DECIM_LSB));
         g = 0;
         repeat (8) begin
            send(1'b1, n);
            g += n;
         end
         chk("decimated", 8 >> k, g);
      end
      $display("test frames done");
      for (int t = 0; t < 2; t++) begin
         wr(OFS_FRAME_CTL, 8'(t << TIME_BIT));
         @(posedge ref_clk);
         lastFrameRead <= 1'b1;
         @(posedge ref_clk);
         lastFrameRead <= 1'b0;
         #1;
         chk("time frame", t, timeFrameReq);
      end
      $display("test time frame done");
      for (int r = 11; r > 6; r--) begin
         wr(OFS_AUX_POLL, 8'(r));
         gap(1'b0, 1'b0, g);
         chk("poll period", 40 << (11 - r), g);
      end
      wr(OFS_AUX_POLL, 8'h1B);
      gap(1'b1, 1'b0, g);
      chk("trigger offset", 8, g);
      wr(OFS_AUX_POLL, 8'h0B);
      gap(1'b0, 1'b1, g);
      chk("zero offset", 1, g);
      for (int r = 12; r < 17; r++) begin
         wr(OFS_AUX_POLL, 8'(r & 15));
         repeat (4) @(posedge ref_clk);
         g = 0;
         repeat (200) begin
            @(posedge ref_clk);
            #1;
            if ((auxReadout | auxTrigger) !== 1'b0) g++;
         end
         chk("reserved rate", 0, g);
      end
      $display("test poll done");
      report_and_stop();
   end
endmodule
bind fap_config_bank fap_config_bank_chk fap_config_bank_chk_inst (
   .ref_clk, .sys_rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
   .auxValid, .auxAxes, .fifoFull, .fifoLevel, .lastFrameRead, .frameWr,
   .frame, .timeFrameReq, .watermarkHit, .auxTrigger, .auxReadout,
   .auxTargetAddr);
